/* verilog/ebau_pkg.sv */
// ebau_pkg: constants, register map and operation codes of the
// eight-bit arithmetic unit.
// assumes: a 32-bit APB slave port, 8-bit byte address.
package ebau_pkg;

  localparam int unsigned DW = 8;
  localparam int unsigned FW = 4;
  localparam int unsigned AW = 8;

  // register byte offsets
  localparam logic [AW-1:0] OFS_WORK   = 8'h00;
  localparam logic [AW-1:0] OFS_FLAGS  = 8'h04;
  localparam logic [AW-1:0] OFS_MULOP  = 8'h08;
  localparam logic [AW-1:0] OFS_PRODHI = 8'h0C;
  localparam logic [AW-1:0] OFS_STATUS = 8'h10;

  // flag bit positions
  localparam int unsigned FLG_ZERO = 0;
  localparam int unsigned FLG_CARRY = 1;
  localparam int unsigned FLG_HALF = 2;
  localparam int unsigned FLG_WRAP = 3;

  // status bit positions
  localparam int unsigned STS_BADOP = 0;

  // reset values
  localparam logic [DW-1:0] WORK_RST   = 8'h00;
  localparam logic [FW-1:0] FLAGS_RST  = 4'h0;
  localparam logic [DW-1:0] MULOP_RST  = 8'h00;
  localparam logic [DW-1:0] PRODHI_RST = 8'h00;

  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] BYTE_ONE  = 8'h01;

  typedef enum logic [3:0] {
    OP_ADD_IMM  = 4'h0,
    OP_ADD_MEM  = 4'h1,
    OP_ADDC_MEM = 4'h2,
    OP_ADDC_ONE = 4'h3,
    OP_NADD     = 4'h4,
    OP_SUB_IMM  = 4'h5,
    OP_SUB_MEM  = 4'h6,
    OP_SUBC_MEM = 4'h7,
    OP_SUBC_ONE = 4'h8,
    OP_INC      = 4'h9,
    OP_DEC      = 4'hA,
    OP_CLEAR    = 4'hB,
    OP_MUL      = 4'hC
  } ebau_op_e;

endpackage : ebau_pkg

/* verilog/ebau_addsub.sv */
// ebau_addsub: 8-bit adder/subtractor with the four status flags.
// assumes: purely combinational, driven by the unit's operand muxes.
`timescale 1ns/1ps
module ebau_addsub (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cy_in,
  input  wire logic       do_sub,
  output logic      [7:0] sum,
  output logic            carry,
  output logic            half,
  output logic            wrap,
  output logic            zero
);

  logic [7:0] b_eff;
  logic       c_eff;
  logic [8:0] full;
  logic [4:0] low;

  // subtraction as a plus inverted b plus inverted borrow
  assign b_eff = do_sub ? ~b : b;
  assign c_eff = do_sub ? ~cy_in : cy_in;
  assign full  = {1'b0, a} + {1'b0, b_eff} + {8'h00, c_eff};
  assign low   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
  assign sum   = full[7:0];
  // carry out of bit 7, borrow when subtracting
  assign carry = do_sub ? ~full[8] : full[8];
  assign half  = do_sub ? ~low[4] : low[4];
  // signed overflow: same-sign inputs give other-sign result
  assign wrap  = (a[7] == b_eff[7]) && (sum[7] != a[7]);
  assign zero  = (sum == 8'h00);

endmodule : ebau_addsub

/* verilog/ebau_core.sv */
// ebau_core: eight-bit arithmetic unit with working register, flags,
// multiplier operand and product-high register, APB register access.
// assumes: sequencer issues one operation per op_valid/op_ready
// handshake and supplies the addressed memory byte on mem_rdata.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module ebau_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        op_valid,
  output logic             op_ready,
  input  wire logic [3:0]  op_code,
  input  wire logic        op_to_mem,
  input  wire logic [7:0]  op_imm,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_we,
  output logic      [7:0]  mem_wdata,
  output logic      [7:0]  working_register,
  output logic      [3:0]  flags
);

  logic [7:0]  work_r;
  logic [3:0]  flags_r;
  logic [7:0]  mulop_r;
  logic [7:0]  prodhi_r;
  logic        badop_r;
  logic        mem_we_r;
  logic [7:0]  mem_wdata_r;
  logic [31:0] prdata_r;

  logic [7:0]  a_sel;
  logic [7:0]  b_sel;
  logic        cy_in;
  logic        do_sub;
  logic        to_mem;
  logic        to_work;
  logic        flag_upd;
  logic        legal;
  logic        clr;
  logic        mul;
  logic [7:0]  sum;
  logic        f_carry;
  logic        f_half;
  logic        f_wrap;
  logic        f_zero;
  logic [15:0] prod;
  logic        op_fire;
  logic        apb_wr;
  logic        sel_work;
  logic        sel_flags;
  logic        sel_mulop;
  logic        sel_prodhi;
  logic        sel_status;
  logic        mapped;
  logic [31:0] rd_mux;

  // register decode
  assign sel_work   = (paddr == ebau_pkg::OFS_WORK);
  assign sel_flags  = (paddr == ebau_pkg::OFS_FLAGS);
  assign sel_mulop  = (paddr == ebau_pkg::OFS_MULOP);
  assign sel_prodhi = (paddr == ebau_pkg::OFS_PRODHI);
  assign sel_status = (paddr == ebau_pkg::OFS_STATUS);
  assign mapped     = sel_work | sel_flags | sel_mulop | sel_prodhi
                    | sel_status;

  assign apb_wr   = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_r;
  // register writes and operations never share an edge
  assign op_ready = !apb_wr;
  assign op_fire  = op_valid && op_ready;

  assign mem_we           = mem_we_r;
  assign mem_wdata        = mem_wdata_r;
  assign working_register = work_r;
  assign flags            = flags_r;

  // operand steering per operation
  always_comb begin
    a_sel    = work_r;
    b_sel    = ebau_pkg::BYTE_ZERO;
    cy_in    = 1'b0;
    do_sub   = 1'b0;
    to_mem   = 1'b0;
    to_work  = 1'b0;
    flag_upd = 1'b1;
    legal    = 1'b1;
    clr      = 1'b0;
    mul      = 1'b0;
    unique case (ebau_pkg::ebau_op_e'(op_code))
      ebau_pkg::OP_ADD_IMM: begin
        b_sel   = op_imm;
        to_work = 1'b1;
      end
      ebau_pkg::OP_ADD_MEM: begin
        b_sel   = mem_rdata;
        to_mem  = op_to_mem;
        to_work = !op_to_mem;
      end
      ebau_pkg::OP_ADDC_MEM: begin
        b_sel   = mem_rdata;
        cy_in   = flags_r[ebau_pkg::FLG_CARRY];
        to_mem  = op_to_mem;
        to_work = !op_to_mem;
      end
      ebau_pkg::OP_ADDC_ONE: begin
        a_sel   = op_to_mem ? mem_rdata : work_r;
        cy_in   = flags_r[ebau_pkg::FLG_CARRY];
        to_mem  = op_to_mem;
        to_work = !op_to_mem;
      end
      ebau_pkg::OP_NADD: begin
        do_sub = 1'b1;
        if (op_to_mem) begin
          a_sel  = work_r;
          b_sel  = mem_rdata;
          to_mem = 1'b1;
        end else begin
          a_sel   = mem_rdata;
          b_sel   = work_r;
          to_work = 1'b1;
        end
      end
      ebau_pkg::OP_SUB_IMM: begin
        b_sel   = op_imm;
        do_sub  = 1'b1;
        to_work = 1'b1;
      end
      ebau_pkg::OP_SUB_MEM: begin
        do_sub = 1'b1;
        if (op_to_mem) begin
          a_sel  = mem_rdata;
          b_sel  = work_r;
          to_mem = 1'b1;
        end else begin
          b_sel   = mem_rdata;
          to_work = 1'b1;
        end
      end
      ebau_pkg::OP_SUBC_MEM: begin
        do_sub = 1'b1;
        cy_in  = flags_r[ebau_pkg::FLG_CARRY];
        if (op_to_mem) begin
          a_sel  = mem_rdata;
          b_sel  = work_r;
          to_mem = 1'b1;
        end else begin
          b_sel   = mem_rdata;
          to_work = 1'b1;
        end
      end
      ebau_pkg::OP_SUBC_ONE: begin
        a_sel   = op_to_mem ? mem_rdata : work_r;
        cy_in   = flags_r[ebau_pkg::FLG_CARRY];
        do_sub  = 1'b1;
        to_mem  = op_to_mem;
        to_work = !op_to_mem;
      end
      ebau_pkg::OP_INC: begin
        a_sel  = mem_rdata;
        b_sel  = ebau_pkg::BYTE_ONE;
        to_mem = 1'b1;
      end
      ebau_pkg::OP_DEC: begin
        a_sel  = mem_rdata;
        b_sel  = ebau_pkg::BYTE_ONE;
        do_sub = 1'b1;
        to_mem = 1'b1;
      end
      ebau_pkg::OP_CLEAR: begin
        clr      = 1'b1;
        to_mem   = 1'b1;
        flag_upd = 1'b0;
      end
      ebau_pkg::OP_MUL: begin
        mul      = 1'b1;
        flag_upd = 1'b0;
      end
      default: begin
        legal    = 1'b0;
        flag_upd = 1'b0;
      end
    endcase
  end

  ebau_addsub u_addsub (
    .a      (a_sel),
    .b      (b_sel),
    .cy_in  (cy_in),
    .do_sub (do_sub),
    .sum    (sum),
    .carry  (f_carry),
    .half   (f_half),
    .wrap   (f_wrap),
    .zero   (f_zero)
  );

  assign prod = {8'h00, work_r} * {8'h00, mulop_r};

  // working register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_r <= ebau_pkg::WORK_RST;
    end else if (op_fire && mul) begin
      work_r <= prod[7:0];
    end else if (op_fire && to_work) begin
      work_r <= sum;
    end else if (apb_wr && sel_work) begin
      work_r <= pwdata[7:0];
    end
  end

  // status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= ebau_pkg::FLAGS_RST;
    end else if (op_fire && flag_upd) begin
      flags_r[ebau_pkg::FLG_ZERO]  <= f_zero;
      flags_r[ebau_pkg::FLG_CARRY] <= f_carry;
      flags_r[ebau_pkg::FLG_HALF]  <= f_half;
      flags_r[ebau_pkg::FLG_WRAP]  <= f_wrap;
    end else if (apb_wr && sel_flags) begin
      flags_r <= pwdata[3:0];
    end
  end

  // multiplier operand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mulop_r <= ebau_pkg::MULOP_RST;
    end else if (apb_wr && sel_mulop) begin
      mulop_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prodhi_r <= ebau_pkg::PRODHI_RST;
    end else if (op_fire && mul) begin
      prodhi_r <= prod[15:8];
    end
  end

  // memory write-back, one-cycle strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_we_r    <= 1'b0;
      mem_wdata_r <= ebau_pkg::BYTE_ZERO;
    end else begin
      mem_we_r <= op_fire && to_mem;
      if (op_fire && to_mem) begin
        mem_wdata_r <= clr ? ebau_pkg::BYTE_ZERO : sum;
      end
    end
  end

  // illegal code sticky, write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      badop_r <= 1'b0;
    end else if (op_fire && !legal) begin
      badop_r <= 1'b1;
    end else if (apb_wr && sel_status && pwdata[ebau_pkg::STS_BADOP]) begin
      badop_r <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_work) begin
      rd_mux[7:0] = work_r;
    end
    if (sel_flags) begin
      rd_mux[3:0] = flags_r;
    end
    if (sel_mulop) begin
      rd_mux[7:0] = mulop_r;
    end
    if (sel_prodhi) begin
      rd_mux[7:0] = prodhi_r;
    end
    if (sel_status) begin
      rd_mux[ebau_pkg::STS_BADOP] = badop_r;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

endmodule : ebau_core

/* testbench/ebau_mem_model.sv */
// ebau_mem_model: one data-memory byte on the unit's far side.
// assumes: bench preloads the byte; the unit writes it via mem_we.
`timescale 1ns/1ps
module ebau_mem_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ld,
  input  wire logic [7:0] ld_val,
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_wdata,
  output logic      [7:0] mem_rdata
);
  // unit write wins over a bench preload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mem_rdata <= 8'h00;
    else if (mem_we) mem_rdata <= mem_wdata;
    else if (ld) mem_rdata <= ld_val;
  end
endmodule : ebau_mem_model

/* testbench/ebau_core_checker.sv */
// ebau_core_checker: timing relations on the operation port.
// assumes: bound to ebau_core, single pclk domain.
`timescale 1ns/1ps
module ebau_core_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       op_valid,
  input wire logic       op_ready,
  input wire logic [3:0] op_code,
  input wire logic       op_to_mem,
  input wire logic [7:0] op_imm,
  input wire logic [7:0] mem_rdata,
  input wire logic       mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] working_register,
  input wire logic [3:0] flags,
  input wire logic       pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic tk;
  assign tk = op_valid && op_ready;
  add_imm_a:
  assert property (tk && op_code == 4'h0 |=> !mem_we && working_register
    == $past(working_register) + $past(op_imm)) else $error("add imm");
  zero_flag_a:
  assert property (tk && op_code == 4'h0 |=>
    flags[0] == (working_register == 8'h00)) else $error("zero flag");
  sub_imm_a:
  assert property (tk && op_code == 4'h5 |=> working_register
    == $past(working_register) - $past(op_imm)) else $error("sub imm");
  sub_work_a:
  assert property (tk && op_code == 4'h6 && !op_to_mem |=> working_register
    == $past(working_register) - $past(mem_rdata)) else $error("sub mem");
  sub_mem_a:
  assert property (tk && op_code == 4'h6 && op_to_mem |=> mem_we && mem_wdata
    == $past(mem_rdata) - $past(working_register)) else $error("sub to mem");
  inc_mem_a:
  assert property (tk && op_code == 4'h9 |=> mem_we &&
    mem_wdata == $past(mem_rdata) + 8'h01) else $error("increment");
  dec_mem_a:
  assert property (tk && op_code == 4'hA |=> mem_we &&
    mem_wdata == $past(mem_rdata) - 8'h01) else $error("decrement");
  clear_mem_a:
  assert property (tk && op_code == 4'hB |=> mem_we && mem_wdata == 8'h00
    && $stable(flags)) else $error("clear");
  mul_flags_a:
  assert property (tk && op_code == 4'hC |=> !mem_we && $stable(flags))
    else $error("multiply flags");
  cover property (tk && op_code == 4'hC);
  cover property (tk && op_code == 4'hB);
  cover property (pslverr);
endmodule : ebau_core_checker

bind ebau_core ebau_core_checker u_ebau_core_checker (
  .pclk(pclk), .presetn(presetn), .op_valid(op_valid),
  .op_ready(op_ready), .op_code(op_code), .op_to_mem(op_to_mem),
  .op_imm(op_imm), .mem_rdata(mem_rdata), .mem_we(mem_we),
  .mem_wdata(mem_wdata), .working_register(working_register),
  .flags(flags), .pslverr(pslverr));

/* testbench/eight_bit_arith_unit_tb.sv */
// eight_bit_arith_unit_tb: random and corner operations on ebau_core.
// assumes: registers set over APB, memory byte from ebau_mem_model.
`timescale 1ns/1ps
module eight_bit_arith_unit_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        op_valid, op_ready, op_to_mem, mem_we, ld, er;
  logic [3:0]  op_code, flags;
  logic [7:0]  paddr, op_imm, mem_rdata, mem_wdata, working_register;
  logic [7:0]  ld_val;
  logic [31:0] pwdata, prdata, d, r;
  int          fails, checks;

  ebau_core u_ebau_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .op_to_mem(op_to_mem), .op_imm(op_imm), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_wdata(mem_wdata),
    .working_register(working_register), .flags(flags));
  ebau_mem_model u_ebau_mem_model (.pclk(pclk), .presetn(presetn),
    .ld(ld), .ld_val(ld_val), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task stop_test;
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // use_op picks op_ready, otherwise pready is awaited
  task automatic wait_hi(input logic use_op);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((use_op ? op_ready : pready) !== 1'b1 && n < 50);
    if ((use_op ? op_ready : pready) !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask : wait_hi

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(1'b0);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] calc(input logic [3:0] c,
    input logic tm, input logic [7:0] w, m, i, input logic cf);
    logic [7:0] x, y, s;
    logic       ci, sb, h, v;
    logic [8:0] t;
    x = tm ? m : w;
    y = tm ? w : m;
    ci = 1'b0;
    sb = c inside {[4'h4:4'h8], 4'hA};
    case (c)
      4'h0, 4'h5: begin x = w; y = i; end
      4'h2, 4'h7: ci = cf;
      4'h3, 4'h8: begin y = 8'h00; ci = cf; end
      4'h4: begin x = tm ? w : m; y = tm ? m : w; end
      4'h9, 4'hA: begin x = m; y = 8'h01; end
      default: ;
    endcase
    t = sb ? {1'b0, x} - y - ci : {1'b0, x} + y + ci;
    h = sb ? ({1'b0, x[3:0]} < {1'b0, y[3:0]} + ci)
           : ({1'b0, x[3:0]} + y[3:0] + ci > 5'h0F);
    s = t[7:0];
    v = (s[7] != x[7]) && ((x[7] != y[7]) == sb);
    return {v, h, t[8], s == 8'h00, s};
  endfunction : calc

  task run(input logic [3:0] c, input logic tm, input logic [7:0] w, m,
    input logic [7:0] i, input logic cf);
    logic [11:0] e;
    logic [15:0] p;
    logic [3:0]  fl;
    logic [7:0]  ew, em;
    fl = 4'h0;
    fl[ebau_pkg::FLG_CARRY] = cf;
    p = w * i;
    e = calc(c, tm, w, m, i, cf);
    ew = w;
    em = m;
    if (c == 4'hC) ew = p[7:0];
    else if (c == 4'hB) em = 8'h00;
    else if (c < 4'hB) begin
      fl = e[11:8];
      if (c > 4'h8 || (tm && c != 4'h0 && c != 4'h5)) em = e[7:0];
      else ew = e[7:0];
    end
    apb(1'b1, ebau_pkg::OFS_WORK, {24'h0, w});
    apb(1'b1, ebau_pkg::OFS_FLAGS, {31'h0, cf} << ebau_pkg::FLG_CARRY);
    apb(1'b1, ebau_pkg::OFS_MULOP, {24'h0, i});
    ld <= 1'b1;
    ld_val <= m;
    @(posedge pclk);
    ld <= 1'b0;
    op_valid <= 1'b1;
    op_code <= c;
    op_to_mem <= tm;
    op_imm <= i;
    wait_hi(1'b1);
    op_valid <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk(working_register, ew);
    chk(flags, fl);
    chk(mem_rdata, em);
    apb(1'b0, ebau_pkg::OFS_PRODHI, 32'h0);
    if (c == 4'hC) chk(d, p[15:8]);
    apb(1'b0, ebau_pkg::OFS_STATUS, 32'h0);
    chk(d, c > 4'hC);
    apb(1'b1, ebau_pkg::OFS_STATUS, 32'h1);
  endtask : run

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {op_valid, op_code, op_to_mem, op_imm, ld, ld_val} = '0;
    fails = 0;
    checks = 0;
    void'($urandom(32'hD6CD));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, ebau_pkg::OFS_PRODHI, 32'hFF);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(d, 32'h0);
      chk(er, k == 5);
    end
    run(4'h0, 1'b0, 8'hFF, 8'h00, 8'h01, 1'b0);
    run(4'h1, 1'b1, 8'h88, 8'h88, 8'h00, 1'b0);
    run(4'h2, 1'b0, 8'h7F, 8'h00, 8'h00, 1'b1);
    run(4'h3, 1'b1, 8'h00, 8'hFF, 8'h00, 1'b1);
    run(4'h4, 1'b0, 8'h01, 8'h00, 8'h00, 1'b0);
    run(4'h4, 1'b1, 8'h10, 8'h20, 8'h00, 1'b0);
    run(4'h5, 1'b0, 8'h80, 8'h00, 8'h01, 1'b0);
    run(4'h6, 1'b0, 8'h10, 8'h01, 8'h00, 1'b0);
    run(4'h6, 1'b1, 8'h01, 8'h80, 8'h00, 1'b0);
    run(4'h7, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1);
    run(4'h7, 1'b1, 8'h05, 8'h05, 8'h00, 1'b1);
    run(4'h8, 1'b1, 8'h00, 8'h00, 8'h00, 1'b1);
    run(4'h9, 1'b1, 8'h00, 8'hFF, 8'h00, 1'b0);
    run(4'hA, 1'b1, 8'h00, 8'h00, 8'h00, 1'b1);
    run(4'hB, 1'b1, 8'h33, 8'h5A, 8'h00, 1'b1);
    run(4'hC, 1'b0, 8'hA5, 8'h00, 8'h5A, 1'b0);
    run(4'hF, 1'b1, 8'h12, 8'h34, 8'h56, 1'b1);
    repeat (150) begin
      r = $urandom;
      run(r[3:0], r[4], r[15:8], r[23:16], r[31:24], r[5]);
    end
    stop_test();
  end
endmodule : eight_bit_arith_unit_tb
